// ===== design/timer_cfg.svh
// Offsets, field positions and constant values of the dual counter block
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// Register offsets
`define OFF_BYTE_CTL     4'h0
`define OFF_SHARED_CTL   4'h1
`define OFF_WORD_CTL     4'h2
`define OFF_BYTE_RELOAD  4'h4
`define OFF_WORD_HOLD_LO 4'h6
`define OFF_WORD_HOLD_HI 4'h7
`define OFF_WCAP_LO      4'h8
`define OFF_WCAP_HI      4'h9
`define OFF_BCAP_LO      4'hA
`define OFF_BCAP_HI      4'hB
`define OFF_IRQ_STATUS   4'hC
`define OFF_IRQ_CLEAR    4'hD
`define OFF_IRQ_ENABLE   4'hE

// Byte and word control fields
`define BIT_RUN          7
`define BIT_SINGLE       6
`define BIT_TMO          5
`define BIT_PRE_HI       4
`define BIT_PRE_LO       3
`define BIT_CAP_IE       2
`define BIT_TMO_IE       1
`define BIT_PIN_SEL      0

// Shared control fields
`define BIT_ALT_MODE     7
`define BIT_P36_EN       6
`define BIT_FN_HI        5
`define BIT_FN_LO        4
`define BIT_DEMOD        3
`define BIT_EDGE_NEG     1
`define BIT_EDGE_POS     0

// Interrupt status bit positions
`define IRQ_BCAP         0
`define IRQ_BTMO         1
`define IRQ_WCAP         2
`define IRQ_WTMO         3

// Values
`define BYTE_FULL        8'hFF
`define BYTE_ZERO        8'h00
`define WORD_ZERO        16'h0000
`define FN_AND           2'h0
`define FN_OR            2'h1
`define FN_NOR           2'h2
`define FN_NAND          2'h3

`endif

// ===== design/timer_pkg.sv
// Types shared by the dual counter block
package timer_pkg;

   // Prescaler state
   typedef struct packed {
      logic [2:0] cnt;
      logic       tick;
   } prescale_state_t;

   // Whole state of the counter block
   typedef struct packed {
      logic       b_run;
      logic       b_tmo;
      logic [1:0] b_pre;
      logic       b_cap_ie;
      logic       b_tmo_ie;
      logic       b_pin_sel;
      logic       alt_mode;
      logic       p36_en;
      logic [1:0] p36_fn;
      logic       demod;
      logic       edge_neg;
      logic       edge_pos;
      logic       w_run;
      logic       w_single;
      logic       w_tmo;
      logic [1:0] w_pre;
      logic       w_cap_ie;
      logic       w_tmo_ie;
      logic       w_pin_sel;
      logic [7:0] b_reload;
      logic [7:0] w_hold_lo;
      logic [7:0] w_hold_hi;
      logic [7:0] b_cnt;
      logic [15:0] w_cnt;
      logic [7:0] b_cap_hi;
      logic [7:0] b_cap_lo;
      logic [7:0] w_cap_hi;
      logic [7:0] w_cap_lo;
      logic [3:0] irq_stat;
      logic [3:0] irq_en;
      logic       demod_prev;
      logic       b_out;
      logic       w_out;
      logic       p34;
      logic       p35;
      logic       p36;
      logic       irq;
      logic [7:0] rdata;
   } timer_state_t;

endpackage : timer_pkg

// ===== design/clock_prescaler.sv
// Divide-by-1/2/4/8 tick generator for one counter
`timescale 1ns/1ns
`default_nettype none
module clock_prescaler
   import timer_pkg::*;
#(
   parameter int CNT_W = 3
) (
   input  wire logic       clk_sys, // System clock
   input  wire logic       rst,     // Async reset, high
   input  wire logic [1:0] sel,     // 0 clk, 1 half, 2 quarter, 3 eighth
   output logic            tick     // One-cycle count pulse
);

   prescale_state_t s_q;
   prescale_state_t s_d;
   logic [CNT_W-1:0] mask;

   // Next divider state
   always_comb begin
      mask = CNT_W'((1 << sel) - 1);
      s_d = s_q;
      s_d.cnt = s_q.cnt + 3'h1;
      s_d.tick = ((s_q.cnt & mask) == mask);
   end

   // State register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

endmodule : clock_prescaler
`default_nettype wire

// ===== design/dual_counter_capture_output.sv
// Byte and word counters with capture, alternation and pin routing
`include "timer_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module dual_counter_capture_output
   import timer_pkg::*;
(
   input  wire logic       clk_sys,       // System clock
   input  wire logic       rst,           // Power-on reset, async high
   input  wire logic       stop_recovery, // Stop recovery reset pulse
   input  wire logic [3:0] addr,          // Register offset
   input  wire logic [7:0] wdata,         // Write data
   input  wire logic       wr,            // Write strobe
   input  wire logic       rd,            // Read strobe
   output logic      [7:0] rdata,         // Read data, cycle after rd
   input  wire logic       demod_in,      // Pulse input to demodulate
   input  wire logic [2:0] port_data,     // Port data for bits 6:4
   output logic            port3_bit4,    // Pin bit 4
   output logic            port3_bit5,    // Pin bit 5
   output logic            port3_bit6,    // Pin bit 6
   output logic            irq            // Level interrupt
);

   timer_state_t s_q;
   timer_state_t s_d;
   logic         b_tick;
   logic         w_tick;
   logic         wr_b;
   logic         wr_s;
   logic         wr_w;
   logic         neg_edge;
   logic         pos_edge;
   logic         comb_out;
   logic [3:0]   ev;

   // Byte counter clock divider
   clock_prescaler #(.CNT_W(3)) u_byte_pre (
      .clk_sys (clk_sys),
      .rst     (rst),
      .sel     (s_q.b_pre),
      .tick    (b_tick)
   );

   // Word counter clock divider
   // word clock select
   clock_prescaler #(.CNT_W(3)) u_word_pre (
      .clk_sys (clk_sys),
      .rst     (rst),
      .sel     (s_q.w_pre),
      .tick    (w_tick)
   );

   // Decodes and input edges
   assign wr_b = wr && (addr == `OFF_BYTE_CTL);
   assign wr_s = wr && (addr == `OFF_SHARED_CTL);
   assign wr_w = wr && (addr == `OFF_WORD_CTL);
   assign neg_edge = s_q.demod_prev && !demod_in;
   assign pos_edge = !s_q.demod_prev && demod_in;

   // Next state of the whole block
   always_comb begin
      s_d = s_q;
      ev = 4'h0;
      s_d.demod_prev = demod_in;

      // Control register writes
      if (wr_b) begin
         s_d.b_run = wdata[`BIT_RUN];
         s_d.b_pre = wdata[`BIT_PRE_HI:`BIT_PRE_LO];
         s_d.b_cap_ie = wdata[`BIT_CAP_IE];
         s_d.b_tmo_ie = wdata[`BIT_TMO_IE];
         s_d.b_pin_sel = wdata[`BIT_PIN_SEL];
         if (wdata[`BIT_TMO]) begin
            s_d.b_tmo = 1'b0;
         end
         if (wdata[`BIT_RUN] && !s_q.b_run) begin
            s_d.b_cnt = s_q.demod ? `BYTE_FULL : s_q.b_reload;
         end
      end
      if (wr_s) begin
         s_d.alt_mode = wdata[`BIT_ALT_MODE];
         s_d.p36_en = wdata[`BIT_P36_EN];
         s_d.p36_fn = wdata[`BIT_FN_HI:`BIT_FN_LO];
         s_d.demod = wdata[`BIT_DEMOD];
         if (wdata[`BIT_EDGE_NEG]) begin
            s_d.edge_neg = 1'b0;
         end
         if (wdata[`BIT_EDGE_POS]) begin
            s_d.edge_pos = 1'b0;
         end
      end
      if (wr_w) begin
         s_d.w_run = wdata[`BIT_RUN];
         s_d.w_single = wdata[`BIT_SINGLE];
         s_d.w_pre = wdata[`BIT_PRE_HI:`BIT_PRE_LO];
         s_d.w_cap_ie = wdata[`BIT_CAP_IE];
         s_d.w_tmo_ie = wdata[`BIT_TMO_IE];
         s_d.w_pin_sel = wdata[`BIT_PIN_SEL];
         if (wdata[`BIT_TMO]) begin
            s_d.w_tmo = 1'b0;
         end
         if (wdata[`BIT_RUN] && !s_q.w_run) begin
            s_d.w_cnt = {s_q.w_hold_hi, s_q.w_hold_lo};
         end
      end
      if (wr && addr == `OFF_BYTE_RELOAD) begin
         s_d.b_reload = wdata;
      end
      if (wr && addr == `OFF_WORD_HOLD_LO) begin
         s_d.w_hold_lo = wdata;
      end
      if (wr && addr == `OFF_WORD_HOLD_HI) begin
         s_d.w_hold_hi = wdata;
      end
      if (wr && addr == `OFF_IRQ_ENABLE) begin
         s_d.irq_en = wdata[3:0];
      end
      if (wr && addr == `OFF_IRQ_CLEAR) begin
         s_d.irq_stat = s_q.irq_stat & ~wdata[3:0];
      end

      // Byte counter
      if (s_q.b_run) begin
         if (s_q.demod && (neg_edge || pos_edge)) begin
            if (neg_edge) begin
               s_d.b_cap_hi = s_q.b_cnt;
               s_d.edge_neg = 1'b1;
            end else begin
               s_d.b_cap_lo = s_q.b_cnt;
               s_d.edge_pos = 1'b1;
            end
            ev[`IRQ_BCAP] = 1'b1;
            s_d.b_cnt = `BYTE_FULL;
         end else if (b_tick) begin
            if (s_q.b_cnt == `BYTE_ZERO) begin
               s_d.b_tmo = 1'b1;
               ev[`IRQ_BTMO] = 1'b1;
               if (s_q.demod) begin
                  // wrap to full and go on
                  s_d.b_cnt = `BYTE_FULL;
               end else begin
                  s_d.b_cnt = s_q.b_reload;
                  s_d.b_out = !s_q.b_out;
                  if (s_q.alt_mode) begin
                     s_d.b_run = 1'b0;
                     s_d.w_run = 1'b1;
                     s_d.w_cnt = {s_q.w_hold_hi, s_q.w_hold_lo};
                  end
               end
            end else begin
               s_d.b_cnt = s_q.b_cnt - 8'h01;
            end
         end
      end

      // Word counter
      if (s_q.w_run) begin
         // edge response only with bit 6 clear
         if (s_q.demod && !s_q.w_single && (neg_edge || pos_edge)) begin
            // word capture split in two bytes
            s_d.w_cap_hi = s_q.w_cnt[15:8];
            s_d.w_cap_lo = s_q.w_cnt[7:0];
            s_d.w_cnt = {s_q.w_hold_hi, s_q.w_hold_lo};
            ev[`IRQ_WCAP] = 1'b1;
         end else if (w_tick) begin
            if (s_q.w_cnt == `WORD_ZERO) begin
               s_d.w_tmo = 1'b1;
               ev[`IRQ_WTMO] = 1'b1;
               s_d.w_cnt = {s_q.w_hold_hi, s_q.w_hold_lo};
               if (!s_q.demod) begin
                  s_d.w_out = !s_q.w_out;
                  if (s_q.w_single) begin
                     s_d.w_run = 1'b0;
                  end
                  if (s_q.alt_mode) begin
                     s_d.w_run = 1'b0;
                     s_d.b_run = 1'b1;
                     s_d.b_cnt = s_q.b_reload;
                  end
               end
            end else begin
               s_d.w_cnt = s_q.w_cnt - 16'h0001;
            end
         end
      end

      // Sticky status, set wins over clear
      // word events gated by enables
      // byte capture gated by byte enable
      s_d.irq_stat[`IRQ_BCAP] = s_d.irq_stat[`IRQ_BCAP]
                                | (ev[`IRQ_BCAP] & s_q.b_cap_ie);
      // byte timeout gated by byte enable
      s_d.irq_stat[`IRQ_BTMO] = s_d.irq_stat[`IRQ_BTMO]
                                | (ev[`IRQ_BTMO] & s_q.b_tmo_ie);
      s_d.irq_stat[`IRQ_WCAP] = s_d.irq_stat[`IRQ_WCAP]
                                | (ev[`IRQ_WCAP] & s_q.w_cap_ie);
      s_d.irq_stat[`IRQ_WTMO] = s_d.irq_stat[`IRQ_WTMO]
                                | (ev[`IRQ_WTMO] & s_q.w_tmo_ie);
      s_d.irq = |(s_d.irq_stat & s_d.irq_en);

      // Stop recovery clears run, timeout, mode, pin and output fields; keeps the rest
      if (stop_recovery) begin
         s_d.b_run = 1'b0;
         s_d.b_tmo = 1'b0;
         s_d.b_tmo_ie = 1'b0;
         s_d.b_pin_sel = 1'b0;
         s_d.w_run = 1'b0;
         s_d.w_single = 1'b0;
         s_d.w_tmo = 1'b0;
         s_d.w_tmo_ie = 1'b0;
         s_d.w_pin_sel = 1'b0;
         s_d.alt_mode = 1'b0;
         s_d.p36_en = 1'b0;
         s_d.demod = 1'b0;
         s_d.b_out = 1'b0;
         s_d.w_out = 1'b0;
      end

      // Pin routing
      // output combination
      unique case (s_d.p36_fn)
         `FN_AND:  comb_out = s_d.b_out & s_d.w_out;
         `FN_OR:   comb_out = s_d.b_out | s_d.w_out;
         `FN_NOR:  comb_out = ~(s_d.b_out | s_d.w_out);
         `FN_NAND: comb_out = ~(s_d.b_out & s_d.w_out);
      endcase
      s_d.p34 = s_d.b_pin_sel ? s_d.b_out : port_data[0];
      s_d.p35 = s_d.w_pin_sel ? s_d.w_out : port_data[1];
      s_d.p36 = s_d.p36_en ? comb_out : port_data[2];

      // Read data, valid the cycle after rd
      s_d.rdata = 8'h00;
      if (rd) begin
         unique case (addr)
            `OFF_BYTE_CTL: begin
               s_d.rdata = {s_q.b_run, 1'b0, s_q.b_tmo, s_q.b_pre,
                            s_q.b_cap_ie, s_q.b_tmo_ie, s_q.b_pin_sel};
            end
            `OFF_SHARED_CTL: begin
               s_d.rdata = {s_q.alt_mode, s_q.p36_en, s_q.p36_fn,
                            s_q.demod, 1'b0, s_q.edge_neg, s_q.edge_pos};
            end
            `OFF_WORD_CTL: begin
               s_d.rdata = {s_q.w_run, s_q.w_single, s_q.w_tmo, s_q.w_pre,
                            s_q.w_cap_ie, s_q.w_tmo_ie, s_q.w_pin_sel};
            end
            `OFF_BYTE_RELOAD:  s_d.rdata = s_q.b_reload;
            `OFF_WORD_HOLD_LO: s_d.rdata = s_q.w_hold_lo;
            `OFF_WORD_HOLD_HI: s_d.rdata = s_q.w_hold_hi;
            `OFF_WCAP_LO:      s_d.rdata = s_q.w_cap_lo;
            `OFF_WCAP_HI:      s_d.rdata = s_q.w_cap_hi;
            `OFF_BCAP_LO:      s_d.rdata = s_q.b_cap_lo;
            `OFF_BCAP_HI:      s_d.rdata = s_q.b_cap_hi;
            `OFF_IRQ_STATUS:   s_d.rdata = {4'h0, s_q.irq_stat};
            `OFF_IRQ_ENABLE:   s_d.rdata = {4'h0, s_q.irq_en};
            default:           s_d.rdata = 8'h00;
         endcase
      end
   end

   // State register; power-on reset clears all
   // run clears at reset
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Registered outputs
   assign rdata = s_q.rdata;
   assign port3_bit4 = s_q.p34;
   assign port3_bit5 = s_q.p35;
   assign port3_bit6 = s_q.p36;
   assign irq = s_q.irq;

endmodule : dual_counter_capture_output
`default_nettype wire

// ===== verif/counter_checker_sva.sv
// Port-level assertions for the dual counter block
`timescale 1ns/1ns
`default_nettype none
module counter_checker (
   input wire logic       clk_sys,       // System clock
   input wire logic       rst,           // Power-on reset
   input wire logic       stop_recovery, // Stop recovery pulse
   input wire logic [3:0] addr,          // Register offset
   input wire logic [7:0] wdata,         // Write data
   input wire logic       wr,            // Write strobe
   input wire logic       rd,            // Read strobe
   input wire logic [7:0] rdata,         // Read data
   input wire logic       demod_in,      // Pulse input
   input wire logic [2:0] port_data,     // Port data
   input wire logic       port3_bit4,    // Pin bit 4
   input wire logic       port3_bit5,    // Pin bit 5
   input wire logic       port3_bit6,    // Pin bit 6
   input wire logic       irq            // Interrupt
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   logic [7:0] wd_q;  // Write data of the last cycle
   logic       wr2_q; // Last cycle wrote word control
   logic [1:0] pre_q; // Last word prescale select written

   // Helper registers of past bus writes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wd_q  <= 8'h00;
         wr2_q <= 1'b0;
         pre_q <= 2'h0;
      end else begin
         wd_q  <= wdata;
         wr2_q <= wr && addr == 4'h2;
         if (wr && addr == 4'h2) begin
            pre_q <= wdata[4:3];
         end
      end
   end

   // Read data stands one cycle only
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data seen outside a read");
   // Unmapped offset reads zero
   a_unmapped_zero: assert property (rd && addr == 4'hF |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_hold_readback: assert property (
      $past(wr) && $past(addr) == 4'h7 && rd && addr == 4'h7
      |=> rdata == $past(wd_q))
      else $error("hold register readback wrong");
   a_reset_quiet: assert property (
      $fell(rst) |-> !irq && !port3_bit4 && !port3_bit5 && !port3_bit6)
      else $error("outputs not clear after reset");
   a_run_readback: assert property (
      wr2_q && !wd_q[7] && rd && addr == 4'h2 |=> !rdata[7])
      else $error("run bit still set after stop");
   a_pre_kept: assert property (
      rd && addr == 4'h2 |=> rdata[4:3] == pre_q)
      else $error("prescale select lost");
   a_tmo_w1c: assert property (
      wr2_q && wd_q[5] && !wd_q[7] && rd && addr == 4'h2 |=> !rdata[5])
      else $error("timeout flag not cleared");
   a_pin_follow: assert property (
      stop_recovery && !wr ##1 !wr
      |=> {port3_bit6, port3_bit5, port3_bit4} == $past(port_data))
      else $error("pins do not follow port data");
   a_irq_masked: assert property (
      wr && addr == 4'hE && wdata[3:0] == 4'h0 |-> ##2 !irq)
      else $error("interrupt high with all enables off");
endmodule : counter_checker

bind dual_counter_capture_output counter_checker counter_checker_i (
   .clk_sys(clk_sys), .rst(rst), .stop_recovery(stop_recovery),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .demod_in(demod_in), .port_data(port_data), .port3_bit4(port3_bit4),
   .port3_bit5(port3_bit5), .port3_bit6(port3_bit6), .irq(irq));
`default_nettype wire

// ===== verif/pulse_source.sv
// Far-side model: demodulation pulse source and port data
`timescale 1ns/1ns
`default_nettype none
module pulse_source (
   input  wire logic       clk_sys,  // System clock
   output var  logic       demod_in, // Pulse to demodulate
   output var  logic [2:0] port_data // Ordinary port data
);
   // Idle line high, port data low
   initial begin
      demod_in  = 1'b1;
      port_data = 3'h0;
   end

   task automatic set_demod(input logic v);
      @(posedge clk_sys);
      demod_in <= v;
      #1;
   endtask : set_demod

   // New port data just after an edge
   task automatic set_port(input logic [2:0] v);
      @(posedge clk_sys);
      port_data <= v;
      #1;
   endtask : set_port
endmodule : pulse_source
`default_nettype wire

// ===== verif/dual_counter_capture_output_test.sv
// Register-level tests of the dual counter block
`timescale 1ns/1ns
`default_nettype none
module dual_counter_capture_output_test;
   logic       clk_sys;        // System clock
   logic       rst;            // Power-on reset
   logic       stop_recovery;  // Stop recovery pulse
   logic [3:0] addr;           // Register offset
   logic [7:0] wdata;          // Write data
   logic       wr;             // Write strobe
   logic       rd;             // Read strobe
   logic [7:0] rdata;          // Read data
   logic       demod_in;       // Pulse input
   logic [2:0] port_data;      // Port data
   logic       port3_bit4;     // Pin bit 4
   logic       port3_bit5;     // Pin bit 5
   logic       port3_bit6;     // Pin bit 6
   logic       irq;            // Interrupt
   int         num_errors = 0; // Mismatches
   int         checks = 0;     // Comparisons
   int         cycles = 0;     // Cycles run

   dual_counter_capture_output dual_counter_capture_output_i (
      .clk_sys(clk_sys), .rst(rst), .stop_recovery(stop_recovery),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .demod_in(demod_in), .port_data(port_data), .port3_bit4(port3_bit4),
      .port3_bit5(port3_bit5), .port3_bit6(port3_bit6), .irq(irq));
   pulse_source pulse_source_i (.clk_sys(clk_sys), .demod_in(demod_in),
      .port_data(port_data));

   // 100 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Hang guard
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors = num_errors + 1;
         close_out();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One bus cycle, driven at the edge
   task automatic bus(input logic w, input logic r, input logic [3:0] a,
                      input logic [7:0] d);
      @(posedge clk_sys);
      wr            <= w;
      rd            <= r;
      addr          <= a;
      wdata         <= d;
      stop_recovery <= 1'b0;
   endtask : bus

   // Read, then compare data in the following cycle
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      #1;
      chk(rdata, exp);
   endtask : rd_chk

   task automatic idle(input int n);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : idle

   // Stop recovery for one cycle; next bus call drops it
   task automatic pulse_stop();
      @(posedge clk_sys);
      stop_recovery <= 1'b1;
      wr            <= 1'b0;
      rd            <= 1'b0;
   endtask : pulse_stop

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   // Main sequence
   initial begin
      rst = 1'b1;
      stop_recovery = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      rd_chk(4'h2, 8'h00);
      rd_chk(4'hF, 8'h00);
      pulse_source_i.set_port(3'h5);
      idle(2);
      chk({5'h00, port3_bit6, port3_bit5, port3_bit4}, 8'h05);
      $display("reset test done");
      // Prescale select across stop recovery
      bus(1'b1, 1'b0, 4'h2, 8'h19);
      pulse_stop();
      rd_chk(4'h2, 8'h18);
      bus(1'b1, 1'b0, 4'h2, 8'h00);
      // Single pass word timeout with interrupt
      bus(1'b1, 1'b0, 4'hE, 8'h0F);
      bus(1'b1, 1'b0, 4'h2, 8'hC2);
      idle(8);
      rd_chk(4'h2, 8'h62);
      rd_chk(4'hC, 8'h08);
      chk({7'h00, irq}, 8'h01);
      bus(1'b1, 1'b0, 4'h2, 8'h62);
      rd_chk(4'h2, 8'h42);
      bus(1'b1, 1'b0, 4'hD, 8'h08);
      idle(2);
      chk({7'h00, irq}, 8'h00);
      bus(1'b1, 1'b0, 4'h7, 8'hA5);
      rd_chk(4'h7, 8'hA5);
      $display("word test done");
      // Demodulation: fall, rise, fall ten cycles apart
      bus(1'b1, 1'b0, 4'h1, 8'h08);
      bus(1'b1, 1'b0, 4'h0, 8'h84);
      idle(3);
      for (int i = 0; i < 3; i++) begin
         pulse_source_i.set_demod(i[0]);
         repeat (9) @(posedge clk_sys);
      end
      idle(3);
      rd_chk(4'hA, 8'hF6);
      rd_chk(4'hB, 8'hF6);
      rd_chk(4'h1, 8'h0B);
      rd_chk(4'hC, 8'h01);
      bus(1'b1, 1'b0, 4'hA, 8'h55);
      rd_chk(4'hA, 8'hF6);
      bus(1'b1, 1'b0, 4'h1, 8'h0B);
      rd_chk(4'h1, 8'h08);
      idle(300);
      rd_chk(4'h0, 8'hA4);
      bus(1'b1, 1'b0, 4'hD, 8'h0F);
      rd_chk(4'hC, 8'h00);
      $display("demodulation test done");
      // Pin routing and output combinations
      pulse_source_i.set_port(3'h7);
      pulse_stop();
      bus(1'b1, 1'b0, 4'h0, 8'h01);
      bus(1'b1, 1'b0, 4'h2, 8'h01);
      idle(2);
      chk({6'h00, port3_bit5, port3_bit4}, 8'h00);
      for (int f = 0; f < 4; f++) begin
         bus(1'b1, 1'b0, 4'h1, {2'b01, f[1:0], 4'h0});
         idle(2);
         chk({7'h00, port3_bit6}, {7'h00, f[1]});
      end
      $display("pin test done");
      // Alternation: byte terminal hands the run enable to the word counter
      bus(1'b1, 1'b0, 4'h4, 8'h02);
      bus(1'b1, 1'b0, 4'h7, 8'h01);
      bus(1'b1, 1'b0, 4'h1, 8'h80);
      bus(1'b1, 1'b0, 4'h0, 8'h80);
      idle(8);
      rd_chk(4'h0, 8'h20);
      rd_chk(4'h2, 8'h81);
      bus(1'b1, 1'b0, 4'h2, 8'h00);
      bus(1'b1, 1'b0, 4'hE, 8'h00);
      idle(2);
      chk({7'h00, irq}, 8'h00);
      $display("alternation test done");
      close_out();
   end
endmodule : dual_counter_capture_output_test
`default_nettype wire
